// *** rtl/bfh_dev.sv ***
// Summary of operation
// - Arbiter frozen in S0/S1; float needs strobe off.
// - Fault without ack or stop is error.
// - Late variant: fault after ack is error.
// - Error ends S9, RMW write ends S21.
// - Buses float while fault asserted.
// - After fault clears, stack SR, PC, info.
// - Fetch handler from vector offset 08.
// - Late variant stacks format, offset, 22 words.
// - Late variant reruns whole RMW on return.
// - Fault with stop asserted means retry.
// - Retry floats until stop drops, same cycle.
// - Never retry read-modify-write cycles.
// - Halted while stop held; arbitration still served.
// - Stop pulse lets exactly one cycle run.
// - Fault in exception or reset fetch locks.
// - Fault during retry is no double fault.
// - External reset needs reset and stop.
// - Reset loads stack pointer, PC, level seven.
// - Reset instruction drives reset 124 clocks.
// - Partner holds reset 100 ms, later 10; bfh_ext holds it 132 clocks, on request only.
// - Ignore external reset during reset instruction.
`timescale 1ns/10ps
module bfh_dev import bfh_pkg::*; #(
	parameter bit LATE_ERR = 1'b0
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_in,
	// Bus side.
	bfh_if.dev bus,
	// Core request port.
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire bfh_pkg::bfh_kind_t req_kind_in,
	input wire logic [23:0] req_addr_in,
	input wire logic [15:0] req_wdata_in,
	input wire logic [2:0] req_fc_in,
	input wire logic reset_instr_in,
	// Status to core.
	output logic done_out,
	output logic [15:0] rdata_out,
	output logic [4:0] end_state_out,
	output logic exc_out,
	output logic [4:0] stack_words_out,
	output logic [23:0] vector_addr_out,
	output logic rmw_rerun_out,
	output logic locked_out,
	output logic [2:0] ipl_out
);
	import bfh_pkg::*;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_BUS = 8'h02,
		ST_RETRY = 8'h04,
		ST_FAULT = 8'h08,
		ST_STACK = 8'h10,
		ST_VEC = 8'h20,
		ST_LOCK = 8'h40,
		ST_RSTI = 8'h80
	} bfh_state_t;

	typedef enum logic [2:0] {
		AR_IDLE = 3'h1,
		AR_GRANT = 3'h2,
		AR_OWNED = 3'h4
	} bfh_arb_t;

	typedef struct packed {
		bfh_state_t state;
		bfh_arb_t arb;
		logic early;
		logic ack_seen;
		logic in_exc;
		logic in_retry;
		logic rmw_rerun;
		logic [4:0] cnt;
		logic [7:0] rcnt;
		logic [1:0] vphase;
		logic was_rst;
		bfh_kind_t kind;
		logic [23:0] addr;
		logic [15:0] wdata;
		logic [2:0] fc;
		logic done;
		logic exc;
		logic [4:0] end_st;
		logic [15:0] rdata;
		logic [23:0] vaddr;
		logic [2:0] ipl;
	} bfh_dev_st_t;

	bfh_dev_st_t st_reg, st_next;
	logic [5:0] sy;
	logic ack, fault, stop, req, taken, ext_rst;

	bfh_sync u_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.async_in({bus.transfer_ack_n, bus.bus_fault_n, bus.stop_ext_n,
			bus.mastership_request_n, bus.grant_taken_n, bus.reset_n}),
		.sync_out(sy)
	);
	assign ack = ~sy[5];
	assign fault = ~sy[4];
	assign stop = ~sy[3];
	assign req = ~sy[2];
	assign taken = ~sy[1];
	assign ext_rst = ~sy[0];

	function automatic logic is_rmw(input bfh_kind_t k);
		return k == BFH_RMW_RD || k == BFH_RMW_WR;
	endfunction

	function automatic logic [4:0] end_for(input bfh_kind_t k);
		return (k == BFH_RMW_WR) ? BFH_END_RMW_WR : BFH_END_NORMAL;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic err;
		logic late;
		st_next = st_reg;
		st_next.done = 1'b0;
		st_next.exc = 1'b0;
		err = 1'b0;
		late = 1'b0;
		// Arbitration freezes while a cycle is in its first states.
		if (!st_reg.early) begin
			unique case (st_reg.arb)
				AR_IDLE: if (req) st_next.arb = AR_GRANT;
				AR_GRANT: begin
					if (taken) begin
						st_next.arb = AR_OWNED;
					end else if (!req) begin
						st_next.arb = AR_IDLE;
					end
				end
				AR_OWNED: if (!taken) st_next.arb = AR_IDLE;
			endcase
		end
		st_next.early = 1'b0;
		unique case (st_reg.state)
			ST_IDLE: begin
				if (reset_instr_in) begin
					st_next.state = ST_RSTI;
					st_next.rcnt = 8'h00;
				end else if (req_valid_in && !stop && st_reg.arb == AR_IDLE) begin
					st_next.state = ST_BUS;
					st_next.early = 1'b1;
					st_next.ack_seen = 1'b0;
					st_next.kind = req_kind_in;
					st_next.addr = req_addr_in;
					st_next.wdata = req_wdata_in;
					st_next.fc = req_fc_in;
					st_next.in_retry = 1'b0;
				end
			end
			ST_BUS: begin
				if (fault && !ack && !stop) begin
					err = 1'b1;
				end else if (LATE_ERR && st_reg.ack_seen && fault && !stop) begin
					err = 1'b1;
					late = 1'b1;
				end
				if (fault && stop && !is_rmw(st_reg.kind)) begin
					st_next.state = ST_RETRY;
					st_next.in_retry = 1'b1;
				end else if (fault && is_rmw(st_reg.kind)) begin
					err = 1'b1;
				end
				if (err) begin
					st_next.end_st = end_for(st_reg.kind);
					if (st_reg.in_exc) begin
						st_next.state = ST_LOCK;
					end else begin
						st_next.state = ST_FAULT;
						st_next.rmw_rerun = LATE_ERR && is_rmw(st_reg.kind);
					end
				end else if (st_next.state == ST_BUS) begin
					if (ack && !fault && (!LATE_ERR || st_reg.ack_seen)) begin
						st_next.state = ST_IDLE;
						st_next.done = 1'b1;
						st_next.rdata = bus.rdata;
					end
					st_next.ack_seen = ack;
				end
				if (late) st_next.ack_seen = 1'b0;
			end
			ST_RETRY: begin
				// Same address, code and data are kept for the rerun.
				if (!stop && !fault) begin
					st_next.state = ST_BUS;
					st_next.early = 1'b1;
					st_next.ack_seen = 1'b0;
				end
			end
			ST_FAULT: begin
				if (!fault) begin
					st_next.state = ST_STACK;
					st_next.in_exc = 1'b1;
					st_next.cnt = LATE_ERR ? BFH_STACK_LATE : BFH_STACK_BASE;
					st_next.exc = 1'b1;
				end
			end
			ST_STACK: begin
				if (fault) begin
					st_next.state = ST_LOCK;
				end else if (st_reg.cnt == 5'h01) begin
					st_next.state = ST_VEC;
					st_next.vaddr = BFH_VEC_BUS_FAULT_N;
					st_next.vphase = 2'h2;
				end else begin
					st_next.cnt = st_reg.cnt - 5'h01;
				end
			end
			ST_VEC: begin
				if (fault) begin
					st_next.state = ST_LOCK;
				end else if (st_reg.vphase == 2'h0) begin
					st_next.vphase = 2'h2;
				end else if (ack) begin
					if (st_reg.vphase == 2'h1) begin
						st_next.vaddr = BFH_VEC_PC;
						// One idle cycle keeps the two vector reads apart.
						st_next.vphase = 2'h0;
					end else begin
						st_next.state = ST_IDLE;
						st_next.in_exc = 1'b0;
						st_next.done = 1'b1;
					end
				end
			end
			ST_LOCK: st_next.state = ST_LOCK;
			ST_RSTI: begin
				// External reset is not looked at while counting.
				if (st_reg.rcnt == BFH_RST_INSTR_CYC - 8'h01) begin
					st_next.state = ST_IDLE;
				end
				st_next.rcnt = st_reg.rcnt + 8'h01;
			end
		endcase
		// External reset needs stop too; ignored during the reset instruction.
		st_next.was_rst = ext_rst && stop && st_reg.state != ST_RSTI;
		if (st_next.was_rst) begin
			st_next.state = ST_IDLE;
			st_next.in_exc = 1'b0;
		end else if (st_reg.was_rst) begin
			st_next.state = ST_VEC;
			st_next.in_exc = 1'b1;
			st_next.vaddr = BFH_VEC_SSP;
			st_next.vphase = 2'h1;
			st_next.ipl = BFH_RESET_IPL;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_reg <= '0;
			st_reg.state <= ST_IDLE;
			st_reg.arb <= AR_IDLE;
			st_reg.ipl <= BFH_RESET_IPL;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic driving;
	assign driving = (st_reg.state == ST_BUS || st_reg.state == ST_VEC)
		&& !(st_reg.state == ST_VEC && st_reg.vphase == 2'h0)
		&& st_reg.arb != AR_OWNED;
	assign bus.addr_strobe_n = ~driving;
	assign bus.addr = (st_reg.state == ST_VEC) ? st_reg.vaddr : st_reg.addr;
	assign bus.wdata = st_reg.wdata;
	assign bus.write = st_reg.kind == BFH_WR || st_reg.kind == BFH_RMW_WR;
	assign bus.func_code = st_reg.fc;
	// Float on grant only with strobe off; also in fault, retry and lock states, and when idle while stop holds.
	assign bus.bus_float = (st_reg.arb == AR_OWNED && !driving)
		|| st_reg.state == ST_FAULT || st_reg.state == ST_RETRY
		|| (st_reg.state == ST_IDLE && stop) || st_reg.state == ST_LOCK;
	assign bus.grant_out_n = st_reg.arb == AR_IDLE;
	assign bus.stop_dev_oe = st_reg.state == ST_LOCK;
	assign bus.reset_dev_oe = st_reg.state == ST_RSTI;
	assign req_ready_out = st_reg.state == ST_IDLE && !stop
		&& st_reg.arb == AR_IDLE && !reset_instr_in;
	assign done_out = st_reg.done;
	assign rdata_out = st_reg.rdata;
	assign end_state_out = st_reg.end_st;
	assign exc_out = st_reg.exc;
	assign stack_words_out = LATE_ERR ? BFH_STACK_LATE : BFH_STACK_BASE;
	assign vector_addr_out = st_reg.vaddr;
	assign rmw_rerun_out = st_reg.rmw_rerun;
	assign locked_out = st_reg.state == ST_LOCK;
	assign ipl_out = st_reg.ipl;
endmodule // bfh_dev

// *** rtl/bfh_pkg.sv ***
package bfh_pkg;
	// Bus cycle kinds.
	typedef enum logic [1:0] {
		BFH_RD = 2'h0,
		BFH_WR = 2'h1,
		BFH_RMW_RD = 2'h2,
		BFH_RMW_WR = 2'h3
	} bfh_kind_t;

	// Abort end states.
	localparam logic [4:0] BFH_END_NORMAL = 5'h09;
	localparam logic [4:0] BFH_END_RMW_WR = 5'h15;

	// Vector addresses.
	localparam logic [23:0] BFH_VEC_SSP = 24'h000000;
	localparam logic [23:0] BFH_VEC_PC = 24'h000004;
	localparam logic [23:0] BFH_VEC_BUS_FAULT_N = 24'h000008;
	localparam logic [2:0] BFH_RESET_IPL = 3'h7;

	// Stacking: SR + two PC words + error info.
	localparam logic [4:0] BFH_STACK_BASE = 5'h04;
	// Late variant: SR, PC x2, format, offset, 22 internal words.
	localparam logic [4:0] BFH_STACK_LATE = 5'h1b;

	// Timing.
	localparam int BFH_CLK_HZ = 25000000;
	localparam logic [7:0] BFH_RST_INSTR_CYC = 8'h7c;
	localparam logic [7:0] BFH_EXT_RST_MIN = 8'h0a;
	localparam logic [7:0] BFH_EXT_RST_SAFE = 8'h84;
	localparam int BFH_INIT_RST_MS = 100;
	localparam int BFH_INIT_RST_CYC = BFH_CLK_HZ / 1000 * BFH_INIT_RST_MS;
endpackage

// *** rtl/bfh_if.sv ***
`timescale 1ns/10ps
interface bfh_if;
	logic transfer_ack_n;
	logic bus_fault_n;
	logic stop_ext_n;
	logic stop_dev_oe;
	logic reset_ext_oe;
	logic reset_dev_oe;
	logic mastership_request_n;
	logic grant_out_n;
	logic grant_taken_n;
	logic addr_strobe_n;
	logic bus_float;
	logic [23:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic write;
	logic [2:0] func_code;
	// Open-drain wires resolve from the enables.
	wire stop_n = stop_ext_n & ~stop_dev_oe;
	wire reset_n = ~(reset_ext_oe | reset_dev_oe);

	modport dev (
		input transfer_ack_n, bus_fault_n, stop_ext_n, reset_ext_oe,
		input mastership_request_n, grant_taken_n, rdata, stop_n, reset_n,
		output stop_dev_oe, reset_dev_oe, grant_out_n, addr_strobe_n,
		output bus_float, addr, wdata, write, func_code
	);
	modport ext (
		output transfer_ack_n, bus_fault_n, stop_ext_n, reset_ext_oe,
		output mastership_request_n, grant_taken_n, rdata,
		input stop_dev_oe, reset_dev_oe, grant_out_n, addr_strobe_n,
		input bus_float, addr, wdata, write, func_code, stop_n, reset_n
	);
endinterface

// *** rtl/bfh_sync.sv ***
`timescale 1ns/10ps
module bfh_sync (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_in,
	// Asynchronous levels in, synchronised levels out.
	input wire logic [5:0] async_in,
	output logic [5:0] sync_out
);
	typedef struct packed {
		logic [5:0] s1;
		logic [5:0] s2;
	} bfh_sync_st_t;
	bfh_sync_st_t st_reg, st_next;
	always_comb begin
		st_next.s1 = async_in;
		st_next.s2 = st_reg.s1;
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_reg <= '{s1: 6'h3f, s2: 6'h3f};
		end else begin
			st_reg <= st_next;
		end
	end
	assign sync_out = st_reg.s2;
endmodule // bfh_sync

// *** rtl/bfh_ext.sv ***
`timescale 1ns/10ps
module bfh_ext import bfh_pkg::*; (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_in,
	// Bus side.
	bfh_if.ext bus,
	// User controls.
	input wire logic ack_in,
	input wire logic fault_in,
	input wire logic stop_in,
	input wire logic step_in,
	input wire logic reset_req_in,
	input wire logic master_req_in,
	input wire logic [15:0] rdata_in,
	// User status.
	output logic granted_out,
	output logic halted_out
);
	import bfh_pkg::*;

	typedef struct packed {
		logic ack;
		logic fault;
		logic stop;
		logic stepping;
		logic [7:0] rcnt;
		logic rst;
		logic taken;
		logic [15:0] rdata;
	} bfh_ext_st_t;
	bfh_ext_st_t st_reg, st_next;

	always_comb begin
		st_next = st_reg;
		st_next.ack = ack_in;
		st_next.rdata = rdata_in;
		st_next.fault = fault_in;
		// Fault falls first; stop is held one more cycle.
		st_next.stop = stop_in || (st_reg.fault && !fault_in);
		// Single step: release stop until the strobe shows, then reassert.
		if (step_in) st_next.stepping = 1'b1;
		if (st_reg.stepping) begin
			st_next.stop = !bus.addr_strobe_n ? 1'b1 : 1'b0;
			if (!bus.addr_strobe_n) st_next.stepping = 1'b0;
		end
		// Reset is stretched to the safe length with stop beside it.
		if (reset_req_in && !st_reg.rst) begin
			st_next.rst = 1'b1;
			st_next.rcnt = BFH_EXT_RST_SAFE;
		end else if (st_reg.rst) begin
			st_next.rcnt = st_reg.rcnt - 8'h01;
			if (st_reg.rcnt == 8'h01) st_next.rst = 1'b0;
		end
		if (st_next.rst) st_next.stop = 1'b1;
		st_next.taken = master_req_in && !bus.grant_out_n
			&& bus.addr_strobe_n && bus.transfer_ack_n
			|| (st_reg.taken && master_req_in);
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bus.transfer_ack_n = ~st_reg.ack;
	assign bus.bus_fault_n = ~st_reg.fault;
	assign bus.stop_ext_n = ~st_reg.stop;
	assign bus.reset_ext_oe = st_reg.rst;
	assign bus.mastership_request_n = ~(master_req_in && !st_reg.taken);
	assign bus.grant_taken_n = ~st_reg.taken;
	assign bus.rdata = st_reg.rdata;
	assign granted_out = st_reg.taken;
	assign halted_out = ~bus.stop_n;
endmodule // bfh_ext

// *** bench/bfh_monitor.sv ***
`timescale 1ns/10ps
module bfh_monitor (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_in,
	// Interface signals.
	input wire logic transfer_ack_n,
	input wire logic bus_fault_n,
	input wire logic stop_ext_n,
	input wire logic stop_dev_oe,
	input wire logic reset_dev_oe,
	input wire logic addr_strobe_n,
	input wire logic bus_float,
	input wire logic [23:0] addr,
	input wire logic stop_n,
	input wire logic reset_n
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic [7:0] oe_cnt_reg;
	////////////////////////////////////////
	// Counting beside the pin keeps the pulse check free of long repeats.
	always_ff @(posedge clk_in) begin
		if (rst_in || !reset_dev_oe) begin
			oe_cnt_reg <= 8'h00;
		end else begin
			oe_cnt_reg <= oe_cnt_reg + 8'h01;
		end
	end
	////////////////////////////////////////
	a_float_strobe_off: assert property (bus_float |-> addr_strobe_n)
		else $error("bus floated while strobe active");
	a_fault_floats: assert property ((!bus_fault_n) [*6] |-> bus_float)
		else $error("buses driven during fault");
	a_halt_floats: assert property ((!stop_n) [*6] |-> bus_float)
		else $error("buses driven while halted");
	a_reset_len: assert property ($fell(reset_dev_oe) |-> oe_cnt_reg == 8'h7c)
		else $error("reset pulse length wrong");
	a_lock_holds: assert property (stop_dev_oe && reset_n |=> stop_dev_oe)
		else $error("lock released without reset");
	a_addr_stands: assert property (
		!addr_strobe_n |=> addr_strobe_n || $stable(addr))
		else $error("address changed during cycle");
	a_ack_ends: assert property ($fell(transfer_ack_n) && !addr_strobe_n &&
		bus_fault_n && stop_n |-> ##[1:6] addr_strobe_n)
		else $error("acknowledged cycle did not end");
	a_halt_no_lock: assert property (
		(!stop_ext_n) [*6] |-> !$rose(stop_dev_oe))
		else $error("fault while halted locked the device");
	c_retry: cover property (!bus_fault_n && !stop_ext_n);
	c_lock: cover property ($rose(stop_dev_oe));
	c_reset_out: cover property ($fell(reset_dev_oe));
endmodule // bfh_monitor

// *** bench/tb.sv ***
`timescale 1ns/10ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
	failures++; $display("[ERR] %s expected %h seen %h", n, e, a); end end
`define WAIT(c, n) begin int k; k = 0; do begin @(negedge clk_in); k++; \
	end while ((c) !== 1'b1 && k < 800); `CHK(n, 1'b1, (c)) \
	if ((c) !== 1'b1) stop_test(); end
module tb;
	import bfh_pkg::*;
	logic clk_in, rst_in, req_valid_in, req_ready_out, reset_instr_in;
	bfh_kind_t req_kind_in;
	logic [23:0] req_addr_in, vector_addr_out;
	logic [15:0] req_wdata_in, rdata_out, rdata_in;
	logic [2:0] req_fc_in, ipl_out;
	logic [4:0] end_state_out, stack_words_out;
	logic done_out, exc_out, rmw_rerun_out, locked_out, granted_out;
	logic ack_in, fault_in, stop_in, step_in, reset_req_in, master_req_in;
	logic halted_out;
	int failures = 0;
	int comparisons = 0;
	bfh_if bus ();
	bfh_dev i_bfh_dev (.clk_in, .rst_in, .bus(bus), .req_valid_in,
		.req_ready_out, .req_kind_in, .req_addr_in, .req_wdata_in, .req_fc_in,
		.reset_instr_in, .done_out, .rdata_out, .end_state_out, .exc_out,
		.stack_words_out, .vector_addr_out, .rmw_rerun_out, .locked_out,
		.ipl_out);
	bfh_ext i_bfh_ext (.clk_in, .rst_in, .bus(bus), .ack_in, .fault_in,
		.stop_in, .step_in, .reset_req_in, .master_req_in, .rdata_in,
		.granted_out, .halted_out);
	bfh_monitor i_bfh_monitor (.clk_in, .rst_in,
		.transfer_ack_n(bus.transfer_ack_n), .bus_fault_n(bus.bus_fault_n),
		.stop_ext_n(bus.stop_ext_n), .stop_dev_oe(bus.stop_dev_oe),
		.reset_dev_oe(bus.reset_dev_oe), .addr_strobe_n(bus.addr_strobe_n),
		.bus_float(bus.bus_float), .addr(bus.addr), .stop_n(bus.stop_n),
		.reset_n(bus.reset_n));
	////////////////////////////////////////
	task automatic stop_test();
		if (failures == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic req(input bfh_kind_t k, input logic [23:0] a);
		@(posedge clk_in);
		req_kind_in <= k;
		req_addr_in <= a;
		req_valid_in <= 1'b1;
		`WAIT(req_ready_out, "ready")
		@(posedge clk_in);
		req_valid_in <= 1'b0;
	endtask
	task automatic t_read();
		@(posedge clk_in);
		ack_in <= 1'b1;
		req(BFH_RD, 24'h000100);
		`WAIT(done_out, "done")
		`CHK("rdata", 16'h5a3c, rdata_out)
		@(posedge clk_in);
		ack_in <= 1'b0;
		// The synchronised acknowledge trails the pin by two edges.
		repeat (4) @(posedge clk_in);
	endtask
	// A stop with the fault asks for a retry, except on read-modify-write.
	task automatic t_fault(input bfh_kind_t k, input logic st);
		logic err;
		err = !st || k == BFH_RMW_WR;
		req(k, 24'h0a5a5a);
		@(posedge clk_in);
		fault_in <= 1'b1;
		stop_in <= st;
		`WAIT(bus.bus_float, "float")
		if (err) begin
			`CHK("end", k == BFH_RMW_WR ? BFH_END_RMW_WR : BFH_END_NORMAL,
				end_state_out)
		end
		@(posedge clk_in);
		fault_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		stop_in <= 1'b0;
		if (err) begin
			`WAIT(exc_out, "exc")
			`CHK("words", BFH_STACK_BASE, stack_words_out)
			@(posedge clk_in);
			ack_in <= 1'b1;
			`WAIT(vector_addr_out === BFH_VEC_BUS_FAULT_N, "vector")
		end else begin
			`WAIT(!bus.addr_strobe_n, "rerun")
			`CHK("addr", 24'h0a5a5a, bus.addr)
			`CHK("data", 16'hc33c, bus.wdata)
			@(posedge clk_in);
			ack_in <= 1'b1;
		end
		`WAIT(done_out, "done")
		@(posedge clk_in);
		ack_in <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask
	task automatic t_step();
		@(posedge clk_in);
		stop_in <= 1'b1;
		master_req_in <= 1'b1;
		`WAIT(granted_out, "grant")
		`CHK("halt", 1'b1, halted_out)
		@(posedge clk_in);
		master_req_in <= 1'b0;
		ack_in <= 1'b1;
		req_kind_in <= BFH_RD;
		req_valid_in <= 1'b1;
		repeat (6) @(negedge clk_in);
		`CHK("refused", 1'b0, req_ready_out)
		@(posedge clk_in);
		step_in <= 1'b1;
		@(posedge clk_in);
		step_in <= 1'b0;
		`WAIT(req_ready_out, "step")
		@(posedge clk_in);
		req_valid_in <= 1'b0;
		`WAIT(done_out, "one cycle")
		repeat (4) @(negedge clk_in);
		`CHK("halted", 1'b1, halted_out)
		@(posedge clk_in);
		stop_in <= 1'b0;
		ack_in <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask
	task automatic t_lock();
		req(BFH_RD, 24'h000200);
		@(posedge clk_in);
		fault_in <= 1'b1;
		`WAIT(bus.bus_float, "float")
		@(posedge clk_in);
		fault_in <= 1'b0;
		`WAIT(exc_out, "exc")
		@(posedge clk_in);
		fault_in <= 1'b1;
		`WAIT(locked_out, "lock")
		@(posedge clk_in);
		fault_in <= 1'b0;
		repeat (8) @(negedge clk_in);
		`CHK("stop", 1'b0, bus.stop_n)
		@(posedge clk_in);
		reset_req_in <= 1'b1;
		ack_in <= 1'b1;
		@(posedge clk_in);
		reset_req_in <= 1'b0;
		`WAIT(vector_addr_out === BFH_VEC_PC, "reset vector")
		`CHK("ipl", BFH_RESET_IPL, ipl_out)
		`CHK("lock", 1'b0, locked_out)
		repeat (8) @(posedge clk_in);
		ack_in <= 1'b0;
	endtask
	task automatic t_reset_instr();
		@(posedge clk_in);
		reset_instr_in <= 1'b1;
		`WAIT(!bus.reset_n, "reset out")
		@(posedge clk_in);
		reset_instr_in <= 1'b0;
		`WAIT(bus.reset_n, "reset end")
		`CHK("ipl kept", BFH_RESET_IPL, ipl_out)
	endtask
	////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	initial begin
		rst_in <= 1'b1;
		req_valid_in <= 1'b0;
		req_kind_in <= BFH_RD;
		req_addr_in <= 24'h000000;
		req_wdata_in <= 16'hc33c;
		req_fc_in <= 3'h5;
		reset_instr_in <= 1'b0;
		rdata_in <= 16'h5a3c;
		{ack_in, fault_in, stop_in, step_in} <= 4'h0;
		{reset_req_in, master_req_in} <= 2'h0;
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		t_read();
		t_fault(BFH_RD, 1'b0);
		t_fault(BFH_RMW_WR, 1'b1);
		t_fault(BFH_WR, 1'b1);
		t_step();
		t_lock();
		t_reset_instr();
		stop_test();
	end
endmodule // tb
